// *** uart_irq_pkg.sv ***
// constants and carrier types for the uart interrupt enable and status block
package uart_irq_pkg;

	// register indices on the internal register port
	localparam logic [3:0] ADDR_RX_HOLD = 4'h0;
	localparam logic [3:0] ADDR_TX_HOLD = 4'h0;
	localparam logic [3:0] ADDR_IER = 4'h1;
	localparam logic [3:0] ADDR_ISR = 4'h2;
	localparam logic [3:0] ADDR_LSR = 4'h5;
	localparam logic [3:0] ADDR_MSR = 4'h6;
	localparam logic [3:0] ADDR_GPIO_LVL = 4'h8;

	// enable register fields
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LINE = 2;
	localparam int IER_MODEM = 3;
	localparam int IER_SLEEP = 4;
	localparam int IER_XOFF = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;

	// reset values
	localparam logic [7:0] IER_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [7:0] LSR_RESET = 8'h60;
	localparam logic [7:0] TIMER_RESET = 8'h00;

	// status codes, bits 5..0
	localparam logic [5:0] ISR_LINE = 6'h06;
	localparam logic [5:0] ISR_TIMEOUT = 6'h0C;
	localparam logic [5:0] ISR_RX_DATA = 6'h04;
	localparam logic [5:0] ISR_TX_READY = 6'h02;
	localparam logic [5:0] ISR_MODEM = 6'h00;
	localparam logic [5:0] ISR_FLOW_CHAR = 6'h10;
	localparam logic [5:0] ISR_HANDSHAKE = 6'h20;
	localparam logic [5:0] ISR_NONE = 6'h01;

	// receive time-out: four characters plus twelve bit times
	localparam logic [7:0] TIMEOUT_CHARS = 8'h04;
	localparam logic [7:0] TIMEOUT_EXTRA_BITS = 8'h0C;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} host_req_s;

	typedef struct packed {
		logic fifo_en;
		logic enhanced;
		logic auto_rts;
		logic auto_cts;
		logic err_on_entry;
		logic wake_en;
	} config_s;

	typedef struct packed {
		logic [7:0] fill;
		logic [7:0] trigger;
		logic loaded;
		logic overrun;
		logic entry_err;
		logic [2:0] head_err;
		logic fifo_err_any;
		logic [3:0] char_bits;
		logic bit_tick;
	} rx_status_s;

	typedef struct packed {
		logic thr_empty;
		logic below_trigger;
		logic all_empty;
	} tx_status_s;

	typedef struct packed {
		logic [3:0] modem_delta;
		logic rts_n;
		logic cts_n;
		logic xon_match;
		logic xoff_match;
		logic special_match;
		logic wake;
		logic [7:0] gpio_in;
		logic [7:0] gpio_en;
		logic [7:0] gpio_inv;
	} event_s;

endpackage

// *** uart_irq_ctrl.sv ***
// interrupt enable, prioritised status and clearing for a fifo uart
`timescale 1ns/1ps
`default_nettype none
module uart_irq_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire uart_irq_pkg::host_req_s req,
	output logic [7:0] rdata,
	// uart state
	input wire uart_irq_pkg::config_s cfg,
	input wire uart_irq_pkg::rx_status_s rx,
	input wire uart_irq_pkg::tx_status_s tx,
	input wire uart_irq_pkg::event_s ev,
	// outputs
	output logic irq,
	output logic sleep_mode,
	output logic [7:0] line_status
);

	logic [7:0] ier_reg;
	logic dr_reg, overrun_reg, lsr_int_reg, head_err_prev_reg;
	logic timeout_reg, transmit_ready_event_reg, tx_cond_prev_reg, msr_int_reg;
	logic xo_reg, sp_reg, rts_int_reg, cts_int_reg, rts_prev_reg, cts_prev_reg;
	logic wake_reg, gpio_int_reg;
	logic [7:0] gpio_prev_reg, timer_reg, timer_next;
	logic [7:0] rdata_reg, lsr_reg;
	logic irq_reg;
	logic [5:0] isr_code;
	logic pending, rx_avail, tx_cond;
	logic rd_rhr, wr_thr, rd_isr, rd_lsr, rd_msr, rd_gpio, wr_ier;
	logic err_event, tx_set, expire, rts_rise, cts_rise, gpio_rise;
	logic [7:0] gpio_asserted, timeout_limit;
	logic [7:0] isr_value;

	assign rd_rhr = req.rd && req.addr == uart_irq_pkg::ADDR_RX_HOLD;
	assign wr_thr = req.wr && req.addr == uart_irq_pkg::ADDR_TX_HOLD;
	assign rd_isr = req.rd && req.addr == uart_irq_pkg::ADDR_ISR;
	assign rd_lsr = req.rd && req.addr == uart_irq_pkg::ADDR_LSR;
	assign rd_msr = req.rd && req.addr == uart_irq_pkg::ADDR_MSR;
	assign rd_gpio = req.rd && req.addr == uart_irq_pkg::ADDR_GPIO_LVL;
	assign wr_ier = req.wr && req.addr == uart_irq_pkg::ADDR_IER;

	// enable register; upper half locked unless enhanced functions are on
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ier_reg <= uart_irq_pkg::IER_RESET;
		end else if (wr_ier) begin
			ier_reg[3:0] <= req.wdata[3:0];
			if (cfg.enhanced) begin
				ier_reg[7:4] <= req.wdata[7:4];
			end
		end
	end

	// receive data ready and overrun; set wins over clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dr_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end else begin
			if (rx.loaded) begin
				dr_reg <= 1'b1;
			end else if (rx.fill == 8'h00) begin
				dr_reg <= 1'b0;
			end
			if (rx.overrun) begin
				overrun_reg <= 1'b1;
			end else if (rd_lsr) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	// line error event: entry error when err_on_entry is set, else a head-of-fifo error reaching the holding position
	assign err_event = cfg.err_on_entry ? rx.entry_err
		: (rx.head_err != 3'h0 && !head_err_prev_reg);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			head_err_prev_reg <= 1'b0;
			lsr_int_reg <= 1'b0;
		end else begin
			head_err_prev_reg <= rx.head_err != 3'h0;
			if (ier_reg[uart_irq_pkg::IER_LINE] && (rx.overrun || err_event)) begin
				lsr_int_reg <= 1'b1;
			end else if (rd_lsr || !ier_reg[uart_irq_pkg::IER_LINE]) begin
				lsr_int_reg <= 1'b0;
			end
		end
	end

	// polled mode needs nothing extra: these bits are always live
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lsr_reg <= uart_irq_pkg::LSR_RESET;
		end else begin
			lsr_reg <= {rx.fifo_err_any, tx.all_empty, tx.thr_empty, rx.head_err,
				overrun_reg, dr_reg};
		end
	end

	// level source, so a drain below trigger removes it by itself
	assign rx_avail = cfg.fifo_en ? (rx.fill >= rx.trigger) : (rx.fill != 8'h00);

	// idle timer counts bit ticks while data waits unread in fifo mode
	assign timeout_limit = 8'(uart_irq_pkg::TIMEOUT_CHARS * {4'h0, rx.char_bits})
		+ uart_irq_pkg::TIMEOUT_EXTRA_BITS;
	assign expire = rx.bit_tick && timer_reg == timeout_limit - 8'h01;

	always_comb begin
		timer_next = timer_reg;
		if (rx.loaded || rd_rhr || rx.fill == 8'h00 || !cfg.fifo_en) begin
			timer_next = uart_irq_pkg::TIMER_RESET;
		end else if (expire) begin
			timer_next = uart_irq_pkg::TIMER_RESET;
		end else if (rx.bit_tick && timer_reg != timeout_limit) begin
			timer_next = timer_reg + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			timer_reg <= uart_irq_pkg::TIMER_RESET;
			timeout_reg <= 1'b0;
		end else begin
			timer_reg <= timer_next;
			if (expire && ier_reg[uart_irq_pkg::IER_RX]) begin
				timeout_reg <= 1'b1;
			end else if (rd_rhr || !ier_reg[uart_irq_pkg::IER_RX]) begin
				timeout_reg <= 1'b0;
			end
		end
	end

	// transmit ready: edge of the condition, or enable raised while it holds
	assign tx_cond = cfg.fifo_en ? tx.below_trigger : tx.thr_empty;
	assign tx_set = ier_reg[uart_irq_pkg::IER_TX] && tx_cond && !tx_cond_prev_reg
		|| wr_ier && req.wdata[uart_irq_pkg::IER_TX] && !ier_reg[uart_irq_pkg::IER_TX]
		&& tx_cond;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_cond_prev_reg <= 1'b0;
			transmit_ready_event_reg <= 1'b0;
		end else begin
			tx_cond_prev_reg <= tx_cond;
			if (tx_set) begin
				transmit_ready_event_reg <= 1'b1;
			end else if (wr_thr || rd_isr && isr_code == uart_irq_pkg::ISR_TX_READY
				|| !ier_reg[uart_irq_pkg::IER_TX]) begin
				transmit_ready_event_reg <= 1'b0;
			end
		end
	end

	// modem, flow characters and handshake edges
	assign rts_rise = ev.rts_n && !rts_prev_reg && ier_reg[uart_irq_pkg::IER_RTS] && cfg.auto_rts;
	assign cts_rise = ev.cts_n && !cts_prev_reg && ier_reg[uart_irq_pkg::IER_CTS] && cfg.auto_cts;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			msr_int_reg <= 1'b0;
			rts_prev_reg <= 1'b0;
			cts_prev_reg <= 1'b0;
			rts_int_reg <= 1'b0;
			cts_int_reg <= 1'b0;
		end else begin
			rts_prev_reg <= ev.rts_n;
			cts_prev_reg <= ev.cts_n;
			if (ier_reg[uart_irq_pkg::IER_MODEM] && ev.modem_delta != 4'h0) begin
				msr_int_reg <= 1'b1;
			end else if (rd_msr) begin
				msr_int_reg <= 1'b0;
			end
			if (rts_rise) begin
				rts_int_reg <= 1'b1;
			end else if (rd_msr) begin
				rts_int_reg <= 1'b0;
			end
			if (cts_rise) begin
				cts_int_reg <= 1'b1;
			end else if (rd_msr) begin
				cts_int_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			xo_reg <= 1'b0;
			sp_reg <= 1'b0;
		end else begin
			if (ier_reg[uart_irq_pkg::IER_XOFF] && (ev.xon_match || ev.xoff_match)) begin
				xo_reg <= 1'b1;
			end else if (rd_isr) begin
				xo_reg <= 1'b0;
			end
			if (ier_reg[uart_irq_pkg::IER_XOFF] && ev.special_match) begin
				sp_reg <= 1'b1;
			end else if (rd_isr || rx.loaded) begin
				sp_reg <= 1'b0;
			end
		end
	end

	// wake-up and gpio
	assign gpio_asserted = (ev.gpio_in ^ ev.gpio_inv) & ev.gpio_en;
	assign gpio_rise = (gpio_asserted & ~gpio_prev_reg) != 8'h00;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wake_reg <= 1'b0;
			gpio_prev_reg <= 8'h00;
			gpio_int_reg <= 1'b0;
		end else begin
			gpio_prev_reg <= gpio_asserted;
			if (ev.wake && cfg.wake_en) begin
				wake_reg <= 1'b1;
			end else if (rd_isr) begin
				wake_reg <= 1'b0;
			end
			if (gpio_rise) begin
				gpio_int_reg <= 1'b1;
			end else if (rd_gpio) begin
				gpio_int_reg <= 1'b0;
			end
		end
	end

	// priority encoder; lower sources wait until the higher one is serviced
	always_comb begin
		if (lsr_int_reg) begin
			isr_code = uart_irq_pkg::ISR_LINE;
		end else if (timeout_reg) begin
			isr_code = uart_irq_pkg::ISR_TIMEOUT;
		end else if (rx_avail && ier_reg[uart_irq_pkg::IER_RX]) begin
			isr_code = uart_irq_pkg::ISR_RX_DATA;
		end else if (transmit_ready_event_reg) begin
			isr_code = uart_irq_pkg::ISR_TX_READY;
		end else if (msr_int_reg) begin
			isr_code = uart_irq_pkg::ISR_MODEM;
		end else if (xo_reg || sp_reg) begin
			isr_code = uart_irq_pkg::ISR_FLOW_CHAR;
		end else if (rts_int_reg || cts_int_reg) begin
			isr_code = uart_irq_pkg::ISR_HANDSHAKE;
		end else begin
			isr_code = uart_irq_pkg::ISR_NONE;
		end
	end

	assign isr_value = {cfg.fifo_en, cfg.fifo_en ^ gpio_int_reg, isr_code};
	// wake-up and gpio drive the pin although the code reads idle
	assign pending = isr_code != uart_irq_pkg::ISR_NONE || wake_reg || gpio_int_reg;

	// read data stands from the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_reg <= uart_irq_pkg::RDATA_RESET;
		end else if (req.rd) begin
			case (req.addr)
				uart_irq_pkg::ADDR_IER: rdata_reg <= ier_reg;
				uart_irq_pkg::ADDR_ISR: rdata_reg <= isr_value;
				uart_irq_pkg::ADDR_LSR: rdata_reg <= lsr_reg;
				default: rdata_reg <= uart_irq_pkg::RDATA_RESET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= pending;
		end
	end

	assign rdata = rdata_reg;
	assign irq = irq_reg;
	assign sleep_mode = ier_reg[uart_irq_pkg::IER_SLEEP];
	assign line_status = lsr_reg;

	a_ier_lock: assert property (@(posedge clk) disable iff (!resetn)
		wr_ier && !cfg.enhanced |=> ier_reg[7:4] == $past(ier_reg[7:4]))
		else $error("upper enable bits changed without enhanced mode");
	a_ready_set: assert property (@(posedge clk) disable iff (!resetn)
		rx.loaded |=> dr_reg ##1 lsr_reg[0])
		else $error("data ready not set after load");
	a_line_clear: assert property (@(posedge clk) disable iff (!resetn)
		rd_lsr && !rx.overrun && !err_event |=> !lsr_int_reg)
		else $error("line interrupt survived status read");
	a_line_first: assert property (@(posedge clk) disable iff (!resetn)
		lsr_int_reg |-> isr_code == uart_irq_pkg::ISR_LINE)
		else $error("line source not reported first");
	a_thr_clear: assert property (@(posedge clk) disable iff (!resetn)
		wr_thr && !tx_set |=> !transmit_ready_event_reg)
		else $error("transmit ready not cleared by write");
	a_tx_enable: assert property (@(posedge clk) disable iff (!resetn)
		wr_ier && req.wdata[1] && !ier_reg[1] && tx_cond |=> transmit_ready_event_reg)
		else $error("no transmit interrupt on enable while empty");
	a_timeout_clear: assert property (@(posedge clk) disable iff (!resetn)
		rd_rhr && !expire |=> !timeout_reg)
		else $error("time-out survived receive read");
	a_irq_follow: assert property (@(posedge clk) disable iff (!resetn)
		pending |=> irq)
		else $error("interrupt pin late");
	a_fifo_bit: assert property (@(posedge clk) disable iff (!resetn)
		rd_isr |=> rdata[7] == $past(cfg.fifo_en) && rdata[0] == ($past(isr_code) == 6'h01))
		else $error("status bit 7 or bit 0 wrong");
	a_rts_edge: assert property (@(posedge clk) disable iff (!resetn)
		rts_rise && !rd_msr |=> rts_int_reg ##0 isr_code != uart_irq_pkg::ISR_NONE)
		else $error("rts rise lost");
	a_gpio_clear: assert property (@(posedge clk) disable iff (!resetn)
		rd_gpio && !gpio_rise |=> !gpio_int_reg)
		else $error("gpio interrupt survived level read");

endmodule
`default_nettype wire

// *** uart_irq_host.sv ***
// host side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module uart_irq_host (
	// clock
	input wire logic clk,
	// register port
	output var uart_irq_pkg::host_req_s req,
	input wire logic [7:0] rdata
);
	initial req = '0;
	// one strobe per access, changed only on falling edges
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge clk);
		req.wr <= 1'b0;
	endtask
	// read data is settled by the falling edge after the taking edge
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clk);
		req.rd <= 1'b0;
		d = rdata;
	endtask
endmodule
`default_nettype wire

// *** uart_interrupt_enable_status_tb.sv ***
// self-checking bench for the uart interrupt enable and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module uart_interrupt_enable_status_tb;
	logic clk;
	logic resetn;
	uart_irq_pkg::host_req_s req;
	logic [7:0] rdata;
	uart_irq_pkg::config_s cfg;
	uart_irq_pkg::rx_status_s rx;
	uart_irq_pkg::tx_status_s tx;
	uart_irq_pkg::event_s ev;
	logic irq;
	logic sleep_mode;
	logic [7:0] line_status;
	logic [7:0] d;
	logic [7:0] v;
	int bad_count = 0;
	int compares = 0;

	uart_irq_ctrl i_uart_irq_ctrl (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
		.cfg(cfg), .rx(rx), .tx(tx), .ev(ev), .irq(irq), .sleep_mode(sleep_mode),
		.line_status(line_status));
	uart_irq_host i_uart_irq_host (.clk(clk), .req(req), .rdata(rdata));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// reference: highest pending source picks the code, fifo enable fills bits 7 and 6
	function automatic logic [7:0] isr_exp(int fifo, int line, int rxd, int txr);
		logic [5:0] c;
		c = line ? uart_irq_pkg::ISR_LINE : rxd ? uart_irq_pkg::ISR_RX_DATA :
			txr ? uart_irq_pkg::ISR_TX_READY : uart_irq_pkg::ISR_NONE;
		return {fifo[0], fifo[0], c};
	endfunction

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		i_uart_irq_host.rd(a, v);
		`CHK(v, e)
	endtask

	task automatic settle();
		repeat (3) @(negedge clk);
	endtask

	initial begin
		#(100 * 3000);
		bad_count++;
		finish_test();
	end

	initial begin
		resetn = 1'b0;
		cfg = '0;
		rx = '0;
		tx = '0;
		ev = '0;
		void'($urandom(32'hCA2B));
		repeat (20) @(negedge clk);
		resetn = 1'b1;
		`CHK(irq, 1'b0)
		rd_chk(uart_irq_pkg::ADDR_IER, uart_irq_pkg::IER_RESET);
		rd_chk(uart_irq_pkg::ADDR_ISR, isr_exp(0, 0, 0, 0));
		// upper enable bits need enhanced functions
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			cfg.enhanced = i[1];
			i_uart_irq_host.wr(uart_irq_pkg::ADDR_IER, d);
			rd_chk(uart_irq_pkg::ADDR_IER, i[1] ? d : {4'h0, d[3:0]});
			`CHK(sleep_mode, i[1] ? d[4] : 1'b0)
			i_uart_irq_host.wr(uart_irq_pkg::ADDR_IER, 8'h00);
		end
		cfg.enhanced = 1'b0;
		settle();
		`CHK(irq, 1'b0)
		// transmit ready at enable, then an overrun on top of it
		tx.thr_empty = 1'b1;
		i_uart_irq_host.wr(uart_irq_pkg::ADDR_IER, 8'h06);
		settle();
		`CHK(irq, 1'b1)
		rx.overrun = 1'b1;
		@(negedge clk);
		rx.overrun = 1'b0;
		settle();
		rd_chk(uart_irq_pkg::ADDR_ISR, isr_exp(0, 1, 0, 1));
		rd_chk(uart_irq_pkg::ADDR_LSR, 8'h22);
		settle();
		rd_chk(uart_irq_pkg::ADDR_ISR, isr_exp(0, 0, 0, 1));
		tx.thr_empty = 1'b0;
		settle();
		rd_chk(uart_irq_pkg::ADDR_ISR, isr_exp(0, 0, 0, 0));
		settle();
		`CHK(irq, 1'b0)
		// fifo mode receive trigger
		i_uart_irq_host.wr(uart_irq_pkg::ADDR_IER, 8'h01);
		cfg.fifo_en = 1'b1;
		rx.trigger = 8'h04;
		rx.loaded = 1'b1;
		rx.fill = 8'h04;
		@(negedge clk);
		rx.loaded = 1'b0;
		settle();
		`CHK(line_status[0], 1'b1)
		`CHK(irq, 1'b1)
		rd_chk(uart_irq_pkg::ADDR_ISR, isr_exp(1, 0, 1, 0));
		rx.fill = 8'h03;
		settle();
		rd_chk(uart_irq_pkg::ADDR_ISR, isr_exp(1, 0, 0, 0));
		`CHK(line_status[0], 1'b1)
		rx.fill = 8'h00;
		settle();
		`CHK(line_status[0], 1'b0)
		`CHK(irq, 1'b0)
		// modem delta pulse, held until the clearing read
		i_uart_irq_host.wr(uart_irq_pkg::ADDR_IER, 8'h09);
		ev.modem_delta = 4'h1;
		@(negedge clk);
		ev.modem_delta = 4'h0;
		settle();
		rd_chk(uart_irq_pkg::ADDR_ISR, {2'b11, uart_irq_pkg::ISR_MODEM});
		rd_chk(uart_irq_pkg::ADDR_MSR, 8'h00);
		rd_chk(uart_irq_pkg::ADDR_ISR, 8'hC1);
		// time-out with a zero-bit frame: twelve ticks
		rx.trigger = 8'h08;
		rx.char_bits = 4'h0;
		rx.fill = 8'h02;
		rx.loaded = 1'b1;
		@(negedge clk);
		rx.loaded = 1'b0;
		rx.bit_tick = 1'b1;
		repeat (12) @(negedge clk);
		rx.bit_tick = 1'b0;
		settle();
		rd_chk(uart_irq_pkg::ADDR_ISR, {2'b11, uart_irq_pkg::ISR_TIMEOUT});
		rd_chk(uart_irq_pkg::ADDR_RX_HOLD, 8'h00);
		rd_chk(uart_irq_pkg::ADDR_ISR, 8'hC1);
		// gpio: pin driven although the code reads idle
		ev.gpio_en = 8'h01;
		ev.gpio_in = 8'h01;
		settle();
		`CHK(irq, 1'b1)
		rd_chk(uart_irq_pkg::ADDR_ISR, 8'h81);
		rd_chk(uart_irq_pkg::ADDR_GPIO_LVL, 8'h00);
		ev.gpio_in = 8'h00;
		settle();
		`CHK(irq, 1'b0)
		rd_chk(uart_irq_pkg::ADDR_ISR, 8'hC1);
		finish_test();
	end
endmodule
`default_nettype wire
